// file: shared/expo_status_pkg.sv
package expo_status_pkg;

	// ----------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_AEC_PIXEL_COUNT = 8'd184;
	localparam logic [7:0] IDX_AEC_AVERAGE_LEVEL = 8'd186;
	localparam logic [7:0] IDX_AEC_EXPOSURE_RESULT = 8'd187;
	localparam logic [7:0] IDX_AEC_GAIN_RESULT = 8'd188;
	localparam logic [7:0] IDX_PROBE_CTRL = 8'd192;
	localparam logic [7:0] IDX_GAIN_CTRL = 8'd204;
	localparam logic [7:0] IDX_SEQ_INTEGRATION_STEP = 8'd208;
	localparam logic [7:0] IDX_SEQ_ARRAY_CLEAR_LENGTH = 8'd209;
	localparam logic [7:0] IDX_SEQ_EXPOSURE_NOW = 8'd210;
	localparam logic [7:0] IDX_SEQ_TWO_KNEE_EXPOSURE = 8'd211;
	localparam logic [7:0] IDX_SEQ_THREE_KNEE_EXPOSURE = 8'd212;
	localparam logic [7:0] IDX_SEQ_ANALOG_GAIN_NOW = 8'd213;
	localparam logic [7:0] IDX_SEQ_DIGITAL_GAIN_AND_KNEES = 8'd214;

	// ----------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------
	localparam int PROBE_SEL_LSB = 11;
	localparam int PROBE_SEL_MSB = 13;
	localparam int GAIN_LAT_COMP_BIT = 13;
	localparam int TWO_KNEE_BIT = 12;
	localparam int THREE_KNEE_BIT = 13;
	localparam logic [2:0] PROBE_SEL_RST = 3'h0;
	localparam logic GAIN_LAT_COMP_RST = 1'b0;

	// ----------------------------------------------------------
	// Probe selections
	// ----------------------------------------------------------
	typedef enum logic [2:0] {
		PROBE_OFF = 3'b000,
		PROBE_INT_ROT = 3'b001,
		PROBE_INT_KNEE = 3'b010,
		PROBE_XREAD_BLACK = 3'b011,
		PROBE_FRAME_ROTSTART = 3'b100,
		PROBE_FIRST_ROTSTART = 3'b101,
		PROBE_ROT_XREAD = 3'b110,
		PROBE_XREAD_SPLIT = 3'b111
	} probe_sel_e;

	// ----------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------
	typedef struct packed {
		logic [15:0] pixel_count;
		logic [9:0] average;
		logic [15:0] exposure;
		logic [1:0] mux_gain;
		logic [1:0] afe_gain;
		logic [11:0] digital_gain;
	} aec_calc_s;

	typedef struct packed {
		logic [15:0] integration_step;
		logic [15:0] clear_length;
		logic [15:0] two_knee_exposure;
		logic [15:0] three_knee_exposure;
		logic two_knee_integration;
		logic three_knee_integration;
	} seq_cfg_s;

	typedef struct packed {
		logic frame_start;
		logic frame_end;
		logic integrating;
		logic row_overhead_time;
		logic frame_overhead_time;
		logic xread_start;
		logic black_line;
		logic first_line;
		logic rot_start;
	} seq_evt_s;

endpackage : expo_status_pkg

// file: rtl/exposure_status_and_monitor_mux.sv
// Behaviour
// RULE1 - Exposure loop evaluates and applies new parameters only every second frame.
// RULE2 - With gain latency compensation set, gain lands with matching exposure.
// RULE3 - Loop status refreshes when new values are handed to sequencer.
// RULE4 - Sequencer status refreshes only when values take effect on image.
// RULE5 - Read-only 16-bit count of pixels used for loop statistics.
// RULE6 - Read-only 10-bit average illumination of current frame.
// RULE7 - Loop exposure and three gains latched at frame end.
// RULE8 - Report integration step and array clear length of current frame.
// RULE9 - Report current exposure and both knee exposures; knees not loop driven.
// RULE10 - Report current analog gains and digital gain of current frame.
// RULE11 - Report two-knee and three-knee enables of current frame.
// RULE12 - Two probe outputs chosen by three-bit field in register 192.
// RULE13 - Select 1: integration time and row overhead time.
// RULE14 - Select 2: integration time and knee frame overhead sequence.
// RULE15 - Select 3: horizontal readout start and black line level.
// RULE16 - Select 4: frame start, row overhead start; 5: first line, same.
// RULE17 - Select 6: row overhead, readout start; 7: black, image readout starts.
// RULE18 - Select 0 holds both probe outputs low.
module exposure_status_and_monitor_mux (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [expo_status_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Exposure loop and sequencer
	input wire expo_status_pkg::aec_calc_s aec_calc,
	input wire expo_status_pkg::seq_cfg_s seq_cfg,
	input wire expo_status_pkg::seq_evt_s seq_evt,
	// Probe pins
	output logic probe_out_zero,
	output logic probe_out_one
);
	import expo_status_pkg::*;

	// ----------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------
	probe_sel_e probe_sel_q;
	logic gain_lat_comp_q;
	logic [7:0] idx;
	logic aligned;
	logic wr_take;

	assign idx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign wr_take = psel & penable & pready & pwrite;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			probe_sel_q <= PROBE_OFF;
			gain_lat_comp_q <= GAIN_LAT_COMP_RST;
		end else if (wr_take && aligned) begin
			// RULE12 probe select
			if (idx == IDX_PROBE_CTRL) begin
				probe_sel_q <= probe_sel_e'(
					pwdata[PROBE_SEL_MSB:PROBE_SEL_LSB]);
			end
			// RULE2 compensation enable
			if (idx == IDX_GAIN_CTRL) begin
				gain_lat_comp_q <= pwdata[GAIN_LAT_COMP_BIT];
			end
		end
	end

	// ----------------------------------------------------------
	// Frame pairing
	// ----------------------------------------------------------
	// Exposure needs a frame to settle, so only alternate frames
	logic eval_q;
	logic eval_end;

	assign eval_end = seq_evt.frame_end & eval_q;

	// RULE1 alternate frames
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			eval_q <= 1'b0;
		end else if (seq_evt.frame_end) begin
			eval_q <= ~eval_q;
		end
	end

	// ----------------------------------------------------------
	// Loop status
	// ----------------------------------------------------------
	aec_calc_s aec_q;

	// RULE3 latch on handover
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aec_q <= '0;
		end else if (eval_end) begin
			// RULE5 RULE6 RULE7 frame end
			aec_q <= aec_calc;
		end
	end

	// ----------------------------------------------------------
	// Sequencer pipeline
	// ----------------------------------------------------------
	// Requests wait for frame starts; set beats clear on collision
	logic exp_pend_q;
	logic exp_wait_q;
	logic gain_pend_q;
	logic gain_wait_q;
	logic [15:0] exp_req_q;
	logic [1:0] mux_req_q;
	logic [1:0] afe_req_q;
	logic [11:0] dig_req_q;
	logic fs;

	assign fs = seq_evt.frame_start;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			exp_req_q <= '0;
			mux_req_q <= '0;
			afe_req_q <= '0;
			dig_req_q <= '0;
		end else if (eval_end) begin
			exp_req_q <= aec_calc.exposure;
			mux_req_q <= aec_calc.mux_gain;
			afe_req_q <= aec_calc.afe_gain;
			dig_req_q <= aec_calc.digital_gain;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			exp_pend_q <= 1'b0;
			exp_wait_q <= 1'b0;
		end else begin
			if (eval_end) begin
				exp_pend_q <= 1'b1;
			end else if (fs) begin
				exp_pend_q <= 1'b0;
			end
			if (fs) begin
				exp_wait_q <= exp_pend_q;
			end
		end
	end

	// RULE2 gain follows exposure
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gain_pend_q <= 1'b0;
			gain_wait_q <= 1'b0;
		end else begin
			if (eval_end) begin
				gain_pend_q <= 1'b1;
			end else if (fs) begin
				gain_pend_q <= 1'b0;
			end
			if (fs) begin
				gain_wait_q <= gain_pend_q & gain_lat_comp_q;
			end
		end
	end

	logic gain_apply;
	assign gain_apply = fs & (gain_lat_comp_q ? gain_wait_q :
		gain_pend_q);

	// ----------------------------------------------------------
	// Sequencer status
	// ----------------------------------------------------------
	logic [15:0] seq_exp_q;
	logic [4:0] seq_mux_q;
	logic [7:0] seq_afe_q;
	logic [11:0] seq_dig_q;
	seq_cfg_s seq_cfg_q;

	// RULE4 applied on image
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_exp_q <= '0;
		end else if (fs && exp_wait_q) begin
			// RULE9 current exposure
			seq_exp_q <= exp_req_q;
		end
	end

	// RULE10 current gains
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_mux_q <= '0;
			seq_afe_q <= '0;
			seq_dig_q <= '0;
		end else if (gain_apply) begin
			seq_mux_q <= {3'h0, mux_req_q};
			seq_afe_q <= {6'h00, afe_req_q};
			seq_dig_q <= dig_req_q;
		end
	end

	// RULE8 RULE9 RULE11 frame settings
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_cfg_q <= '0;
		end else if (fs) begin
			seq_cfg_q <= seq_cfg;
		end
	end

	// ----------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------
	// One wait-free access cycle; data prepared in setup
	logic [31:0] rd_d;
	logic hit_d;

	always_comb begin
		rd_d = 32'h0000_0000;
		hit_d = aligned;
		unique case (idx)
			IDX_AEC_PIXEL_COUNT: rd_d[15:0] = aec_q.pixel_count;
			IDX_AEC_AVERAGE_LEVEL: rd_d[9:0] = aec_q.average;
			IDX_AEC_EXPOSURE_RESULT: rd_d[15:0] = aec_q.exposure;
			IDX_AEC_GAIN_RESULT: rd_d[15:0] = {aec_q.digital_gain,
				aec_q.afe_gain, aec_q.mux_gain};
			IDX_PROBE_CTRL:
				rd_d[PROBE_SEL_MSB:PROBE_SEL_LSB] = probe_sel_q;
			IDX_GAIN_CTRL: rd_d[GAIN_LAT_COMP_BIT] = gain_lat_comp_q;
			IDX_SEQ_INTEGRATION_STEP:
				rd_d[15:0] = seq_cfg_q.integration_step;
			IDX_SEQ_ARRAY_CLEAR_LENGTH:
				rd_d[15:0] = seq_cfg_q.clear_length;
			IDX_SEQ_EXPOSURE_NOW: rd_d[15:0] = seq_exp_q;
			IDX_SEQ_TWO_KNEE_EXPOSURE:
				rd_d[15:0] = seq_cfg_q.two_knee_exposure;
			IDX_SEQ_THREE_KNEE_EXPOSURE:
				rd_d[15:0] = seq_cfg_q.three_knee_exposure;
			IDX_SEQ_ANALOG_GAIN_NOW:
				rd_d[12:0] = {seq_afe_q, seq_mux_q};
			IDX_SEQ_DIGITAL_GAIN_AND_KNEES: begin
				rd_d[11:0] = seq_dig_q;
				rd_d[TWO_KNEE_BIT] = seq_cfg_q.two_knee_integration;
				rd_d[THREE_KNEE_BIT] =
					seq_cfg_q.three_knee_integration;
			end
			default: hit_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= ~hit_d;
			prdata <= (pwrite || !hit_d) ? 32'h0000_0000 : rd_d;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Probe outputs
	// ----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			probe_out_zero <= 1'b0;
			probe_out_one <= 1'b0;
		end else begin
			unique case (probe_sel_q)
				// RULE18 idle low
				PROBE_OFF: begin
					probe_out_zero <= 1'b0;
					probe_out_one <= 1'b0;
				end
				// RULE13 integration, overhead
				PROBE_INT_ROT: begin
					probe_out_zero <= seq_evt.integrating;
					probe_out_one <= seq_evt.row_overhead_time;
				end
				// RULE14 integration, knee overhead
				PROBE_INT_KNEE: begin
					probe_out_zero <= seq_evt.integrating;
					probe_out_one <= seq_evt.frame_overhead_time &
						(seq_cfg_q.two_knee_integration |
						seq_cfg_q.three_knee_integration);
				end
				// RULE15 readout, black
				PROBE_XREAD_BLACK: begin
					probe_out_zero <= seq_evt.xread_start;
					probe_out_one <= seq_evt.black_line;
				end
				// RULE16 frame start
				PROBE_FRAME_ROTSTART: begin
					probe_out_zero <= seq_evt.frame_start;
					probe_out_one <= seq_evt.rot_start;
				end
				// RULE16 first line
				PROBE_FIRST_ROTSTART: begin
					probe_out_zero <= seq_evt.first_line;
					probe_out_one <= seq_evt.rot_start;
				end
				// RULE17 overhead, readout
				PROBE_ROT_XREAD: begin
					probe_out_zero <= seq_evt.row_overhead_time;
					probe_out_one <= seq_evt.xread_start;
				end
				// RULE17 split readout
				PROBE_XREAD_SPLIT: begin
					probe_out_zero <= seq_evt.xread_start &
						seq_evt.black_line;
					probe_out_one <= seq_evt.xread_start &
						~seq_evt.black_line;
				end
			endcase
		end
	end

	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_eval_end;
		seq_evt.frame_end && eval_q;
	endsequence

	// Request taken by the first frame start after the evaluation
	sequence s_req_pending;
		fs && exp_pend_q;
	endsequence

	AST_EVEN_FRAMES: assert property ( // RULE1
		$changed(aec_q) |-> $past(eval_end))
		else $error("loop status changed off an evaluation frame");

	AST_ALTERNATE: assert property ( // RULE1
		s_eval_end |=> !eval_q)
		else $error("evaluation did not alternate frames");

	AST_LOOP_LATCH: assert property ( // RULE7
		s_eval_end |=> aec_q.exposure == $past(aec_calc.exposure) &&
			aec_q.digital_gain == $past(aec_calc.digital_gain))
		else $error("loop exposure or gain not latched");

	AST_PIXELS: assert property ( // RULE5
		s_eval_end |=> aec_q.pixel_count == $past(aec_calc.pixel_count)
			&& aec_q.average == $past(aec_calc.average))
		else $error("pixel count or average not latched");

	AST_EXP_WAITS: assert property ( // RULE4
		s_req_pending |=> exp_wait_q)
		else $error("requested exposure not held for the next frame");

	AST_SEQ_ON_START: assert property ( // RULE4
		$changed(seq_exp_q) |-> $past(fs) && $past(exp_wait_q))
		else $error("sequencer exposure changed off a frame start");

	AST_GAIN_COMP: assert property ( // RULE2
		gain_lat_comp_q && $changed(seq_dig_q) |-> $past(exp_wait_q))
		else $error("compensated gain did not land with exposure");

	AST_PROBE_OFF: assert property ( // RULE18
		probe_sel_q == PROBE_OFF |=> !probe_out_zero && !probe_out_one)
		else $error("probe outputs not low when off");

	AST_PROBE_INT: assert property ( // RULE13
		probe_sel_q == PROBE_INT_ROT && $stable(probe_sel_q) |->
			probe_out_zero == $past(seq_evt.integrating))
		else $error("probe zero does not follow integration");

	AST_KNEES: assert property ( // RULE11
		fs |=> seq_cfg_q.two_knee_integration ==
			$past(seq_cfg.two_knee_integration))
		else $error("knee flag not taken at frame start");

endmodule : exposure_status_and_monitor_mux

// file: verification/seq_model.sv
module seq_model (
	// Clock
	input wire logic clk,
	// Sequencer events
	output expo_status_pkg::seq_evt_s evt
);
	timeunit 1ns;
	timeprecision 1ns;
	import expo_status_pkg::*;

	initial evt = '0;

	// One cycle per event, then idle, so pulses never smear
	task automatic show(input logic [8:0] p);
		@(posedge clk);
		evt <= seq_evt_s'(p);
		@(posedge clk);
		evt <= '0;
	endtask : show
endmodule : seq_model

// file: verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import expo_status_pkg::*;

	localparam logic [8:0] FE = 9'h080;
	localparam logic [8:0] FS = 9'h100;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic probe_out_zero;
	logic probe_out_one;
	aec_calc_s aec_calc = '0;
	seq_cfg_s seq_cfg = '{16'h0011, 16'h0022, 16'h0033, 16'h0044, 1'b1, 1'b0};
	seq_evt_s evt;
	int bad_count = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic er;
	logic [8:0] p;
	logic [31:0] pe;
	logic [31:0] pg;
	logic [7:0] regs [13] = '{8'hB8, 8'hBA, 8'hBB, 8'hBC, 8'hC0, 8'hCC,
		8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6};

	always #50 clk = ~clk;

	exposure_status_and_monitor_mux dut (.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .aec_calc(aec_calc), .seq_cfg(seq_cfg),
		.seq_evt(evt), .probe_out_zero(probe_out_zero),
		.probe_out_one(probe_out_one));
	seq_model seq (.clk(clk), .evt(evt));

	// ----------------------------------------------------------
	// Bench tasks
	// ----------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Zero wait states promised, but the wait stays open up to a bound
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk($sformatf("reg %0d", idx), exp, rd);
	endtask : rc

	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	endtask : do_reset

	function automatic logic [1:0] pexp(input logic [2:0] s,
		input seq_evt_s e);
		case (s)
			3'h1: return {e.integrating, e.row_overhead_time};
			3'h2: return {e.integrating, e.frame_overhead_time};
			3'h3: return {e.xread_start, e.black_line};
			3'h4: return {e.frame_start, e.rot_start};
			3'h5: return {e.first_line, e.rot_start};
			3'h6: return {e.row_overhead_time, e.xread_start};
			3'h7: return {e.xread_start & e.black_line,
				e.xread_start & ~e.black_line};
			default: return 2'b00;
		endcase
	endfunction : pexp

	// ----------------------------------------------------------
	// Tests
	// ----------------------------------------------------------
	initial begin
		do_reset();
		foreach (regs[i]) rc(regs[i], 32'h0);
		pg = {30'h0, probe_out_zero, probe_out_one};
		chk("probes idle", 32'h0, pg);
		apb(1'b0, 8'hB9, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, IDX_AEC_PIXEL_COUNT, 32'hFFFF);
		chk("read-only err", 32'h0, {31'h0, er});
		rc(IDX_AEC_PIXEL_COUNT, 32'h0);
		apb(1'b1, IDX_PROBE_CTRL, 32'hFFFF_FFFF);
		rc(IDX_PROBE_CTRL, 32'h3800);
		apb(1'b1, IDX_GAIN_CTRL, 32'hFFFF_FFFF);
		rc(IDX_GAIN_CTRL, 32'h2000);
		$display("test registers done");
		// Frame start comes first so the knee flag is latched for code 2
		for (int s = 0; s < 8; s++) begin
			apb(1'b1, IDX_PROBE_CTRL, 32'(s) << 11);
			for (int b = 0; b < 10; b++) begin
				p = (b < 9) ? (9'h100 >> b) : 9'h00C;
				seq.show(p);
				@(negedge clk);
				pe = {30'h0, pexp(3'(s), seq_evt_s'(p))};
				pg = {30'h0, probe_out_zero, probe_out_one};
				chk("probes", pe, pg);
			end
		end
		$display("test probes done");
		do_reset();
		aec_calc <= '{16'h1234, 10'h2A5, 16'h0456, 2'h1, 2'h3, 12'hABC};
		seq.show(FE);
		rc(IDX_AEC_EXPOSURE_RESULT, 32'h0);
		seq.show(FE);
		rc(IDX_AEC_PIXEL_COUNT, 32'h1234);
		rc(IDX_AEC_AVERAGE_LEVEL, 32'h02A5);
		rc(IDX_AEC_EXPOSURE_RESULT, 32'h0456);
		rc(IDX_AEC_GAIN_RESULT, 32'hABCD);
		rc(IDX_SEQ_ANALOG_GAIN_NOW, 32'h0);
		seq.show(FS);
		rc(IDX_SEQ_ANALOG_GAIN_NOW, 32'h0061);
		rc(IDX_SEQ_DIGITAL_GAIN_AND_KNEES, 32'h1ABC);
		rc(IDX_SEQ_EXPOSURE_NOW, 32'h0);
		rc(IDX_SEQ_INTEGRATION_STEP, 32'h0011);
		rc(IDX_SEQ_ARRAY_CLEAR_LENGTH, 32'h0022);
		rc(IDX_SEQ_TWO_KNEE_EXPOSURE, 32'h0033);
		rc(IDX_SEQ_THREE_KNEE_EXPOSURE, 32'h0044);
		seq.show(FS);
		rc(IDX_SEQ_EXPOSURE_NOW, 32'h0456);
		apb(1'b1, IDX_GAIN_CTRL, 32'h2000);
		aec_calc <= '{16'h1234, 10'h2A5, 16'h0789, 2'h0, 2'h2, 12'h123};
		seq.show(FE);
		rc(IDX_AEC_EXPOSURE_RESULT, 32'h0456);
		seq.show(FE);
		rc(IDX_AEC_EXPOSURE_RESULT, 32'h0789);
		rc(IDX_AEC_GAIN_RESULT, 32'h1238);
		seq.show(FS);
		rc(IDX_SEQ_ANALOG_GAIN_NOW, 32'h0061);
		rc(IDX_SEQ_DIGITAL_GAIN_AND_KNEES, 32'h1ABC);
		seq.show(FS);
		rc(IDX_SEQ_ANALOG_GAIN_NOW, 32'h0040);
		rc(IDX_SEQ_DIGITAL_GAIN_AND_KNEES, 32'h1123);
		rc(IDX_SEQ_EXPOSURE_NOW, 32'h0789);
		// Three-knee only: flag moves, settled gain stays
		seq_cfg <= '{16'h0055, 16'h0066, 16'h0077, 16'h0088, 1'b0, 1'b1};
		seq.show(FS);
		rc(IDX_SEQ_DIGITAL_GAIN_AND_KNEES, 32'h2123);
		rc(IDX_SEQ_INTEGRATION_STEP, 32'h0055);
		// No knees latched: knee overhead probe must stay low
		seq_cfg <= '0;
		seq.show(FS);
		apb(1'b1, IDX_PROBE_CTRL, 32'h0000_1000);
		seq.show(9'h050);
		@(negedge clk);
		pg = {30'h0, probe_out_zero, probe_out_one};
		chk("knee probe", 32'h2, pg);
		$display("test exposure loop done");
		give_verdict();
	end
endmodule : testbench
